// ### hw/sme_regs.vh
// Constants of the serial memory command engine: opcodes, status fields, reset values.
// Assumes inclusion by bare name from the design file only.
`ifndef SME_REGS_VH
`define SME_REGS_VH
`define SME_OP_LATCH_SET 8'h06
`define SME_OP_LATCH_CLEAR 8'h04
`define SME_OP_STATUS_READ 8'h05
`define SME_OP_STATUS_WRITE 8'h01
`define SME_OP_READ 8'h03
`define SME_OP_WRITE 8'h02
`define SME_OP_IDENT_READ 8'h9F
`define SME_OP_FAST_READ 8'h0B
`define SME_OP_QUAD_READ 8'h6B
`define SME_SR_WPEN 7
`define SME_SR_LAT_HI 5
`define SME_SR_LAT_LO 4
`define SME_SR_BP1 3
`define SME_SR_BP0 2
`define SME_SR_WEL 1
`define SME_SR_WPEN_RST 1'h0
`define SME_SR_LAT_RST 2'h0
`define SME_SR_BP_RST 2'h0
`define SME_MODE_KEEP_A 8'hEF
`define SME_MODE_KEEP_B 8'hAF
`define SME_DUMMY_LAT00 6'h06
`define SME_DUMMY_LAT01 6'h04
`define SME_DUMMY_LAT10 6'h02
`define SME_DUMMY_LAT11 6'h00
`define SME_ADDR_BITS 6'h18
`define SME_BYTE_BITS 6'h08
`define SME_QUAD_STEPS 6'h02
`define SME_MODE_STEPS_QUAD 6'h02
`define SME_ID_BITS 6'h20
`endif

// ### hw/sme_engine.v
// Serial memory command engine with its write FIFO toward the memory array.
// Assumes the memory answers a read one core clock after mem_rd_o, and that the
// core clock runs at least eight times faster than the serial clock.
//
// Behaviour
// (RULE1) Write-disable clears the latch; with latch clear, status and array writes do nothing.
// (RULE2) Status read shifts 8 status bits out on falling edges, repeating while clocked.
// (RULE3) Host sends status-write opcode, exactly 8 data bits, then raises select.
// (RULE4) Status write ignores bits 6, 1 and 0; bit 0 always reads zero.
// (RULE5) Host writes zero into both latency bit positions.
// (RULE6) Host keeps write-protect steady during the whole status write.
// (RULE7) Single read takes opcode and 24 address bits, top 5 ignored, then shifts data out.
// (RULE8) Address advances per byte, wraps to zero, continues until select rises.
// (RULE9) Host limits serial clock to 40 MHz for single read, 108 MHz otherwise.
// (RULE10) Single write commits each byte after 8 bits and advances the address.
// (RULE11) Fast read takes opcode, 24 address bits and 8 mode bits before data.
// (RULE12) Mode EF or AF keeps the read mode; next select takes an address directly.
// (RULE13) Any other mode value drops execute-in-place at the next select rise.
// (RULE14) Host never raises select during mode bits or dummy cycles.
// (RULE15) Identifier read shifts out 32 bits, then holds the last bit.
// (RULE16) Identifier order: maker byte, continuation byte, product byte one, product byte two.
// (RULE17) Latency bits pick dummy cycles: 00 six, 01 four, 10 two, 11 none.
// (RULE18) Host keeps serial clock within the limit that the latency setting allows.
// (RULE19) Quad read: address on line zero, mode over four lines, dummies, nibble output.
// (RULE20) Quad read bytes take 2 clocks each and the address advances per byte.
// (RULE21) Quad read uses the same EF or AF execute-in-place scheme.
// (RULE22) Host releases all four lines before the first data falling edge.
// (RULE23) Host sets the latch with write-enable before any write.
// (RULE24) Opcodes are 8-bit codes; write-disable is 04, status read is 05.
// (RULE25) All fields travel most significant bit first; select high resets decoding.
`include "sme_regs.vh"

module sme_fifo #(
  parameter WIDTH = 27,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // Filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;
  assign in_ready_o = (count_q != DEPTH[AW:0]);
  assign out_valid_o = (count_q != {(AW+1){1'b0}});
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
  always @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end
endmodule // sme_fifo

module sme_engine #(
  parameter ADDR_W = 19,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  // Identifier value is arbitrary.
  parameter [31:0] ID_WORD = 32'h5A0C3E97
) (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // Serial link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire [3:0] io_i,
  output wire [3:0] io_o,
  output wire [3:0] io_oe_n_o,
  // Memory read port
  output wire mem_rd_o,
  output wire [ADDR_W-1:0] mem_rd_addr_o,
  input wire [7:0] mem_rd_data_i,
  // Memory write port
  output wire mem_wr_valid_o,
  input wire mem_wr_ready_i,
  output wire [ADDR_W-1:0] mem_wr_addr_o,
  output wire [7:0] mem_wr_data_o,
  // Status
  output wire [7:0] status_o,
  output wire xip_active_o,
  output wire wr_overflow_o
);
  localparam ST_OPC = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_MODE = 4'h2;
  localparam ST_DUMMY = 4'h3;
  localparam ST_RDOUT = 4'h4;
  localparam ST_WRDATA = 4'h5;
  localparam ST_SRWR = 4'h6;
  localparam ST_SROUT = 4'h7;
  localparam ST_IDOUT = 4'h8;
  localparam ST_IGN = 4'h9;
  localparam CMD_READ = 2'h0;
  localparam CMD_FAST = 2'h1;
  localparam CMD_QUAD = 2'h2;
  localparam CMD_WRITE = 2'h3;

  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg sck_d_q;
  reg cs_d_q;
  reg [3:0] state_q;
  reg [1:0] cmd_q;
  reg [5:0] cnt_q;
  reg [27:0] sh_q;
  reg [ADDR_W-1:0] addr_q;
  reg [31:0] out_sr_q;
  reg [5:0] out_cnt_q;
  reg [7:0] next_q;
  reg rd_req_q;
  reg rd_pend_q;
  reg [ADDR_W-1:0] rd_addr_q;
  reg [3:0] io_q;
  reg [3:0] oe_n_q;
  reg wel_q;
  reg wel_clr_pend_q;
  reg wpen_q;
  reg [1:0] lat_q;
  reg [1:0] bp_q;
  reg xip_q;
  reg xip_keep_q;
  reg push_q;
  reg [ADDR_W+7:0] push_data_q;
  reg overflow_q;
  reg [5:0] dummy;
  reg [31:0] src;
  wire cs_n_s;
  wire sck_s;
  wire [3:0] io_s;
  wire sel;
  wire rise;
  wire fall;
  wire cs_rise;
  wire [7:0] in_byte;
  wire [23:0] in_word;
  wire [7:0] quad_mode;
  wire [7:0] mode_val;
  wire [7:0] status;
  wire quad_out;
  wire fifo_ready;

  assign cs_n_s = sync2_q[5];
  assign sck_s = sync2_q[4];
  assign io_s = sync2_q[3:0];
  assign sel = ~cs_n_s;
  assign rise = sel & sck_s & ~sck_d_q;
  assign fall = sel & ~sck_s & sck_d_q;
  assign cs_rise = cs_n_s & ~cs_d_q;
  assign in_byte = {sh_q[6:0], io_s[0]}; // [RULE25]
  assign in_word = {sh_q[22:0], io_s[0]};
  assign quad_mode = {sh_q[3:0], io_s};
  assign mode_val = (cmd_q == CMD_QUAD) ? quad_mode : in_byte;
  assign status = {wpen_q, 1'b0, lat_q, bp_q, wel_q, 1'b0}; // [RULE4]
  assign quad_out = (state_q == ST_RDOUT) && (cmd_q == CMD_QUAD);

  always @* begin
    case (lat_q) // [RULE17]
      2'b00: dummy = `SME_DUMMY_LAT00;
      2'b01: dummy = `SME_DUMMY_LAT01;
      2'b10: dummy = `SME_DUMMY_LAT10;
      default: dummy = `SME_DUMMY_LAT11;
    endcase
  end

  // Reload a fresh byte when the previous one is used up; status repeats itself.
  always @* begin
    src = out_sr_q;
    if (out_cnt_q == 6'h00) begin
      src = {((state_q == ST_SROUT) ? status : next_q), 24'h000000}; // [RULE2]
    end
  end

  // Pins cross into the core clock through two flops before anything reads them.
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_q <= 6'h30;
      sync2_q <= 6'h30;
      sck_d_q <= 1'b1;
      cs_d_q <= 1'b1;
    end else begin
      sync1_q <= {cs_n_i, sck_i, io_i};
      sync2_q <= sync1_q;
      sck_d_q <= sck_s;
      cs_d_q <= cs_n_s;
    end
  end

  always @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ST_OPC;
      cmd_q <= CMD_READ;
      cnt_q <= 6'h00;
      sh_q <= 28'h0000000;
      addr_q <= {ADDR_W{1'b0}};
      out_sr_q <= 32'h00000000;
      out_cnt_q <= 6'h00;
      next_q <= 8'h00;
      rd_req_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= {ADDR_W{1'b0}};
      io_q <= 4'h0;
      oe_n_q <= 4'hF;
      wel_q <= 1'b0;
      wel_clr_pend_q <= 1'b0;
      wpen_q <= `SME_SR_WPEN_RST;
      lat_q <= `SME_SR_LAT_RST;
      bp_q <= `SME_SR_BP_RST;
      xip_q <= 1'b0;
      xip_keep_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= {(ADDR_W+8){1'b0}};
      overflow_q <= 1'b0;
    end else begin
      rd_req_q <= 1'b0;
      rd_pend_q <= rd_req_q;
      push_q <= 1'b0;
      overflow_q <= 1'b0;
      if (rd_pend_q) begin
        next_q <= mem_rd_data_i;
      end
      if (cs_rise) begin
        // Select high ends every command; execute-in-place resumes at the address.
        state_q <= xip_keep_q ? ST_ADDR : ST_OPC; // [RULE25] [RULE12] [RULE13]
        xip_q <= xip_keep_q;
        cnt_q <= 6'h00;
        oe_n_q <= 4'hF;
        if (wel_clr_pend_q) begin
          wel_q <= 1'b0;
        end
        wel_clr_pend_q <= 1'b0;
      end else if (rise) begin
        sh_q <= {sh_q[26:0], io_s[0]}; // [RULE25]
        cnt_q <= cnt_q + 6'h01;
        case (state_q)
          ST_OPC: begin
            if (cnt_q == `SME_BYTE_BITS - 6'h01) begin
              cnt_q <= 6'h00;
              state_q <= ST_IGN;
              case (in_byte) // [RULE24]
                `SME_OP_LATCH_SET: wel_q <= 1'b1;
                `SME_OP_LATCH_CLEAR: wel_q <= 1'b0; // [RULE1]
                `SME_OP_STATUS_READ: begin
                  state_q <= ST_SROUT; // [RULE2]
                  out_cnt_q <= 6'h00;
                end
                `SME_OP_STATUS_WRITE: begin
                  state_q <= ST_SRWR;
                  wel_clr_pend_q <= 1'b1;
                end
                `SME_OP_READ: begin
                  state_q <= ST_ADDR; // [RULE7]
                  cmd_q <= CMD_READ;
                end
                `SME_OP_WRITE: begin
                  state_q <= ST_ADDR; // [RULE10]
                  cmd_q <= CMD_WRITE;
                  wel_clr_pend_q <= 1'b1;
                end
                `SME_OP_IDENT_READ: begin
                  state_q <= ST_IDOUT; // [RULE15]
                  out_sr_q <= ID_WORD; // [RULE16]
                  out_cnt_q <= `SME_ID_BITS;
                end
                `SME_OP_FAST_READ: begin
                  state_q <= ST_ADDR; // [RULE11]
                  cmd_q <= CMD_FAST;
                end
                `SME_OP_QUAD_READ: begin
                  state_q <= ST_ADDR; // [RULE19]
                  cmd_q <= CMD_QUAD;
                end
                default: state_q <= ST_IGN;
              endcase
            end
          end
          ST_ADDR: begin
            if (cnt_q == `SME_ADDR_BITS - 6'h01) begin
              cnt_q <= 6'h00;
              // The top address bits beyond the array are dropped here.
              addr_q <= in_word[ADDR_W-1:0]; // [RULE7]
              rd_addr_q <= in_word[ADDR_W-1:0];
              rd_req_q <= (cmd_q != CMD_WRITE);
              out_cnt_q <= 6'h00;
              case (cmd_q)
                CMD_READ: state_q <= ST_RDOUT;
                CMD_WRITE: state_q <= ST_WRDATA;
                default: state_q <= ST_MODE; // [RULE11] [RULE19]
              endcase
            end
          end
          ST_MODE: begin
            // Only the quad read takes four lines; the fast read keeps shifting line zero.
            if (cmd_q == CMD_QUAD) begin
              sh_q <= {sh_q[23:0], io_s}; // [RULE19]
            end
            if ((cmd_q == CMD_QUAD) ? (cnt_q == `SME_MODE_STEPS_QUAD - 6'h01)
                                    : (cnt_q == `SME_BYTE_BITS - 6'h01)) begin
              cnt_q <= 6'h00;
              // The choice only takes effect at the next select rise, never mid-access.
              xip_keep_q <= (mode_val == `SME_MODE_KEEP_A) ||
                            (mode_val == `SME_MODE_KEEP_B); // [RULE12] [RULE13] [RULE21]
              state_q <= ((cmd_q == CMD_QUAD) && (dummy != 6'h00)) ? ST_DUMMY : ST_RDOUT;
            end
          end
          ST_DUMMY: begin
            if (cnt_q == dummy - 6'h01) begin
              cnt_q <= 6'h00;
              state_q <= ST_RDOUT; // [RULE17]
            end
          end
          ST_WRDATA: begin
            if (cnt_q == `SME_BYTE_BITS - 6'h01) begin
              cnt_q <= 6'h00;
              addr_q <= addr_q + 1'b1; // [RULE8]
              if (wel_q) begin
                push_q <= 1'b1; // [RULE10] [RULE1]
                push_data_q <= {addr_q, in_byte};
              end
            end
          end
          ST_SRWR: begin
            if (cnt_q == `SME_BYTE_BITS - 6'h01) begin
              state_q <= ST_IGN;
              // A low write-protect line on io[2] blocks the status write when protection is enabled.
              if (wel_q && !(wpen_q && !io_s[2])) begin // [RULE1]
                wpen_q <= in_byte[`SME_SR_WPEN]; // [RULE4]
                lat_q <= in_byte[`SME_SR_LAT_HI:`SME_SR_LAT_LO];
                bp_q <= in_byte[`SME_SR_BP1:`SME_SR_BP0];
              end
            end
          end
          default: cnt_q <= 6'h00;
        endcase
      end else if (fall && ((state_q == ST_RDOUT) || (state_q == ST_SROUT) ||
                            (state_q == ST_IDOUT))) begin
        if (!((state_q == ST_IDOUT) && (out_cnt_q == 6'h00))) begin // [RULE15]
          oe_n_q <= quad_out ? 4'h0 : 4'hD;
          if (quad_out) begin
            io_q <= src[31:28]; // [RULE19]
            out_sr_q <= {src[27:0], 4'h0};
          end else begin
            io_q <= {2'b00, src[31], 1'b0}; // [RULE2] [RULE7]
            out_sr_q <= {src[30:0], 1'b0};
          end
          if (out_cnt_q == 6'h00) begin
            out_cnt_q <= (quad_out ? `SME_QUAD_STEPS : `SME_BYTE_BITS) - 6'h01; // [RULE20]
            if (state_q == ST_RDOUT) begin
              addr_q <= addr_q + 1'b1; // [RULE8] [RULE20]
              rd_addr_q <= addr_q + 1'b1;
              rd_req_q <= 1'b1;
            end
          end else begin
            out_cnt_q <= out_cnt_q - 6'h01;
          end
        end
      end
      if (push_q && !fifo_ready) begin
        overflow_q <= 1'b1;
      end
    end
  end

  // The serial source cannot be stalled, so a full FIFO drops the byte and flags it.
  sme_fifo #(
    .WIDTH(ADDR_W + 8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data_q),
    .out_valid_o(mem_wr_valid_o),
    .out_ready_i(mem_wr_ready_i),
    .out_data_o({mem_wr_addr_o, mem_wr_data_o})
  );

  assign io_o = io_q;
  assign io_oe_n_o = oe_n_q;
  assign mem_rd_o = rd_req_q;
  assign mem_rd_addr_o = rd_addr_q;
  assign status_o = status;
  assign xip_active_o = xip_q;
  assign wr_overflow_o = overflow_q;
endmodule // sme_engine

// ### verif/sme_engine_sva.sv
// Concurrent checks on the port behaviour of the serial memory command engine.
// Assumes one core clock domain and a link clock at least eight times slower.
module sme_engine_sva #(
  parameter ADDR_W = 19
) (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_i,
  // Link pins
  input wire cs_n_i,
  input wire sck_i,
  input wire [3:0] io_o,
  input wire [3:0] io_oe_n_o,
  // Memory ports
  input wire mem_rd_o,
  input wire mem_wr_valid_o,
  input wire mem_wr_ready_i,
  input wire [ADDR_W-1:0] mem_wr_addr_o,
  input wire [7:0] mem_wr_data_o,
  // Status
  input wire [7:0] status_o,
  input wire xip_active_o,
  input wire wr_overflow_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  a_idle_release: assert property (cs_n_i [*6] |-> io_oe_n_o == 4'hF)
    else $error("outputs enabled while deselected");
  a_status_fixed: assert property (status_o[0] == 1'b0 && status_o[6] == 1'b0)
    else $error("fixed status bits not zero");
  a_status_idle: assert property (cs_n_i [*6] |=> $stable(status_o))
    else $error("status changed while deselected");
  a_write_latched: assert property ($rose(mem_wr_valid_o) |-> status_o[1])
    else $error("array write without write latch");
  a_head_hold: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
    mem_wr_valid_o && $stable(mem_wr_addr_o) && $stable(mem_wr_data_o))
    else $error("write head changed while stalled");
  a_overflow_full: assert property (wr_overflow_o |-> mem_wr_valid_o ##1 !wr_overflow_o)
    else $error("overflow pulse without full buffer");
  a_read_spacing: assert property (mem_rd_o |=> !mem_rd_o [*3])
    else $error("array reads too close together");
  a_xip_drop: assert property ($fell(xip_active_o) |-> $past(cs_n_i))
    else $error("execute in place dropped while selected");
  a_out_on_fall: assert property (!cs_n_i && $changed(io_o) |->
    !$past(sck_i, 2) || !$past(sck_i, 3))
    else $error("data output changed away from a falling edge");
endmodule // sme_engine_sva

bind sme_engine sme_engine_sva #(.ADDR_W(ADDR_W)) u_sva (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
  .io_o(io_o), .io_oe_n_o(io_oe_n_o), .mem_rd_o(mem_rd_o), .mem_wr_valid_o(mem_wr_valid_o),
  .mem_wr_ready_i(mem_wr_ready_i), .mem_wr_addr_o(mem_wr_addr_o),
  .mem_wr_data_o(mem_wr_data_o), .status_o(status_o), .xip_active_o(xip_active_o),
  .wr_overflow_o(wr_overflow_o));

// ### verif/sme_host.sv
// Host serial controller model that drives the engine's link pins.
// Assumes the bench calls its tasks one after another; the link clock idles high.
module sme_host (
  // Device side
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_n_i,
  // Link pins
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] drv_q = 4'hF;
  logic [3:0] en_q = 4'hF;
  logic [63:0] rx;
  initial cs_n_o = 1'b1;
  initial sck_o = 1'b1;
  // A released line shows the inverse of its last level, so stale data never passes.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      io_o[k] = !dev_oe_n_i[k] ? dev_io_i[k] : (en_q[k] ? drv_q[k] : ~drv_q[k]);
    end
  end
  task automatic sel;
    #1 cs_n_o = 1'b0;
    #32;
  endtask
  task automatic desel;
    #16 cs_n_o = 1'b1;
    en_q = 4'h0;
    #64;
  endtask
  // Clocks n cycles; w leaves MSB first, q picks four lines, rd releases them.
  task automatic shift(input int n, input logic q, input logic rd, input logic [31:0] w);
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      en_q = rd ? 4'h0 : (q ? 4'hF : 4'hD);
      drv_q = rd ? ~drv_q : (q ? w[31:28] : {3'b111, w[31]});
      w = q ? w << 4 : w << 1;
      #16 sck_o = 1'b1;
      #16 rx = q ? {rx[59:0], io_o} : {rx[62:0], io_o[1]};
    end
  endtask
endmodule // sme_host

// ### verif/sme_engine_tb.sv
// Self-checking bench: host model on the link, byte array model on the memory ports.
// Assumes a 4 ns core clock and the host model's 32 ns link clock.
module sme_engine_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // Identifier value is arbitrary.
  localparam logic [31:0] ID = 32'hC3A51E69;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_rdy = 1'b0;
  logic cs_n, sck, mem_rd, wr_vld, ovf, execute_in_place_mode;
  logic [3:0] io_i, io_o, oe_n;
  logic [18:0] rd_addr, wr_addr;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] wr_data, status;
  logic [7:0] mem [0:524287];
  int n_errors = 0;
  int n_checks = 0;
  int n_ovf = 0;
  always #2 core_clk_i = ~core_clk_i;
  sme_host host (.dev_io_i(io_o), .dev_oe_n_i(oe_n), .cs_n_o(cs_n), .sck_o(sck), .io_o(io_i));
  sme_engine #(.ID_WORD(ID)) DUT (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck), .io_i(io_i),
    .io_o(io_o), .io_oe_n_o(oe_n), .mem_rd_o(mem_rd), .mem_rd_addr_o(rd_addr),
    .mem_rd_data_i(rd_data), .mem_wr_valid_o(wr_vld), .mem_wr_ready_i(wr_rdy),
    .mem_wr_addr_o(wr_addr), .mem_wr_data_o(wr_data), .status_o(status),
    .xip_active_o(execute_in_place_mode), .wr_overflow_o(ovf));
  // The array answers one core clock after a read request.
  always @(posedge core_clk_i) begin
    if (mem_rd) rd_data <= mem[rd_addr];
    if (wr_vld && wr_rdy) mem[wr_addr] <= wr_data;
    if (ovf) n_ovf <= n_ovf + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input bit adr);
    host.sel();
    host.shift(8, 1'b0, 1'b0, {op, 24'h0});
    if (adr) host.shift(24, 1'b0, 1'b0, {a, 8'h0});
  endtask
  task automatic op1(input logic [7:0] op);
    cmd(op, 24'h0, 1'b0);
    host.desel();
  endtask
  task automatic sw(input logic [7:0] d);
    cmd(8'h01, 24'h0, 1'b0);
    host.shift(8, 1'b0, 1'b0, {d, 24'h0});
    host.desel();
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(status, 8'h00);
    chk(oe_n, 4'hF);
    $display("Test reset done");
    op1(8'h06);
    chk(status, 8'h02);
    op1(8'h04);
    chk(status, 8'h00);
    sw(8'hCF);
    chk(status, 8'h00);
    op1(8'h06);
    sw(8'hCF);
    chk(status, 8'h8C);
    cmd(8'h05, 24'h0, 1'b0);
    host.shift(16, 1'b0, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[15:0], 16'h8C8C);
    $display("Test status done");
    op1(8'h06);
    cmd(8'h02, 24'hFFFFFE, 1'b1);
    for (int i = 0; i < 9; i++) host.shift(8, 1'b0, 1'b0, {8'h10 + 8'(i), 24'h0});
    host.desel();
    chk(n_ovf, 1);
    chk(status[1], 1'b0);
    @(posedge core_clk_i) wr_rdy <= 1'b1;
    for (int k = 0; k < 200 && wr_vld !== 1'b0; k++) @(posedge core_clk_i);
    if (wr_vld !== 1'b0) begin
      n_errors++;
      tally_and_finish();
    end
    for (int k = 0; k < 8; k++) chk(mem[19'h7FFFE + 19'(k)], 8'h10 + 8'(k));
    $display("Test write done");
    cmd(8'h03, 24'hFFFFFF, 1'b1);
    host.shift(16, 1'b0, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[15:0], 16'h1112);
    cmd(8'h9F, 24'h0, 1'b0);
    host.shift(34, 1'b0, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[33:2], ID);
    chk(host.rx[1:0], {2{ID[0]}});
    $display("Test read done");
    cmd(8'h0B, 24'h0, 1'b1);
    host.shift(8, 1'b0, 1'b0, {8'hEF, 24'h0});
    host.shift(8, 1'b0, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[7:0], 8'h12);
    chk(execute_in_place_mode, 1'b1);
    host.sel();
    host.shift(24, 1'b0, 1'b0, {24'h000001, 8'h0});
    host.shift(16, 1'b0, 1'b0, 32'h0);
    host.desel();
    chk(host.rx[7:0], 8'h13);
    chk(execute_in_place_mode, 1'b0);
    cmd(8'h6B, 24'h000002, 1'b1);
    host.shift(2, 1'b1, 1'b0, {8'hAF, 24'h0});
    host.shift(6, 1'b0, 1'b1, 32'h0);
    host.shift(4, 1'b1, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[15:0], 16'h1415);
    chk(execute_in_place_mode, 1'b1);
    host.sel();
    host.shift(24, 1'b0, 1'b0, {24'h000003, 8'h0});
    host.shift(2, 1'b1, 1'b0, 32'h0);
    host.shift(6, 1'b0, 1'b1, 32'h0);
    host.shift(2, 1'b1, 1'b1, 32'h0);
    host.desel();
    chk(host.rx[7:0], 8'h15);
    chk(execute_in_place_mode, 1'b0);
    $display("Test fast reads done");
    tally_and_finish();
  end
endmodule // sme_engine_tb
